// ==== core/gpio_port.sv ====
// gpio port: wishbone register file, atomic output update, config lock
// Summary of operation
// - a one in bit_set_clear_reg low half sets that output bit
// - a one in bit_set_clear_reg high half clears that output bit
// - when set and clear hit one pin together, set wins
// - bit_set_clear_reg is write-only and reads zero
// - bit_clear_only_reg ones clear output bits; reads zero
// - output_value_reg is 16-bit read/write, shows last produced value
// - pins sampled into input_sample_reg every clock; writes ignored
// - 2-bit mode per pin: input, output, alternate, analog; reset input
// - output type bit per pin: push-pull at reset, one is open-drain
// - 2-bit pull per pin: none, up, down, 11 reserved
// - 4-bit alternate selector per pin; codes 8 to 15 reserved
// - selectors reset to function zero; one function per pin
// - alternate mode: peripheral drives pin, level still sampled
// - lock bits readable always, writable only while key is zero
// - key armed by writes 1,0,1 with same mask then a read
// - wrong step or changed mask aborts the key sequence
// - after locking, locked pin config and lock register are frozen
// - after locking the key bit reads one until reset
// - enabled oscillator owns its pins: driver, pulls and schmitt off; speed_o still follows port config
// - analog mode: driver and pulls off, input sample reads zero
// - open-drain: zero drives low, one releases, input shows pin
module gpio_port
	import gpio_port_pkg::*;
#(
	parameter int num_pins = 16,
	parameter int alt_funcs = 8,
	parameter logic [15:0] fast_osc_pins = 16'h0000,
	parameter logic [15:0] slow_osc_pins = 16'h0000
)(
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic [15:0] pin_in_i,
	output logic [15:0] pin_out_o,
	output logic [15:0] pin_oe_o,
	output logic [15:0] pull_up_en_o,
	output logic [15:0] pull_down_en_o,
	output logic [15:0] schmitt_en_o,
	output logic [31:0] speed_o,
	input wire logic [127:0] alt_out_i,
	input wire logic [127:0] alt_oe_i,
	output logic [127:0] alt_in_o,
	input wire logic fast_osc_enable_i,
	input wire logic slow_osc_enable_i,
	output logic [15:0] osc_owned_o
);
	// elaboration check: lane and selector layout is fixed at 16 by 8
	if (num_pins != 16 || alt_funcs != 8)
	begin : g_bad_params
		$error("gpio_port: only 16 pins and 8 functions supported");
	end

	logic [31:0] pin_mode_reg;
	logic [15:0] output_type_reg;
	logic [31:0] output_speed_reg;
	logic [31:0] pull_config_reg;
	logic [15:0] input_sample_reg;
	logic [15:0] output_value_reg;
	logic [15:0] pin_lock_bit;
	logic lock_key_bit;
	logic [31:0] alt_func_low_reg;
	logic [31:0] alt_func_high_reg;
	lock_seq_e lock_state;
	logic [15:0] seq_mask;
	logic [15:0] sync_a;
	logic [15:0] sync_b;
	logic [15:0] sync_c;
	logic [15:0] pin_level;
	logic req;
	logic wr;
	logic rd;
	logic mapped;
	logic full_word;
	logic [31:0] read_mux;
	logic [31:0] wmask2;
	logic [31:0] wmask4_lo;
	logic [31:0] wmask4_hi;

	// a request is taken the cycle it appears; ack follows one cycle later
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	assign full_word = (wb_sel_i == 4'hF);
	always_comb
	begin
		unique case (wb_adr_i)
			pin_mode_reg_off, output_type_reg_off, output_speed_reg_off,
			pull_config_reg_off, input_sample_reg_off,
			output_value_reg_off, bit_set_clear_reg_off,
			config_lock_reg_off, alt_func_low_reg_off,
			alt_func_high_reg_off, bit_clear_only_reg_off:
				mapped = 1'b1;
			default:
				mapped = 1'b0;
		endcase
	end
	assign wr = req & wb_we_i & mapped;
	assign rd = req & ~wb_we_i & mapped;

	// byte lanes expanded to a bit mask
	logic [31:0] sel_bits;
	assign sel_bits = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// locked pins: mask out 2-bit and 4-bit fields of those pins
	genvar g;
	generate
		for (g = 0; g < 16; g++)
		begin : g_lockmask
			assign wmask2[2*g +: 2] =
				{2{~(lock_key_bit & pin_lock_bit[g])}};
		end
		for (g = 0; g < 8; g++)
		begin : g_lockmask4
			assign wmask4_lo[4*g +: 4] =
				{4{~(lock_key_bit & pin_lock_bit[g])}};
			assign wmask4_hi[4*g +: 4] =
				{4{~(lock_key_bit & pin_lock_bit[g+8])}};
		end
	endgenerate

	// bus answer: ack for mapped, err for unmapped, one cycle each
	always_ff @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
		end
		else
		begin
			wb_ack_o <= req & mapped;
			wb_err_o <= req & ~mapped;
		end
	end

	// read data registered; write-only registers read zero
	always_comb
	begin
		read_mux = zero_word;
		unique case (wb_adr_i)
			pin_mode_reg_off: read_mux = pin_mode_reg;
			output_type_reg_off: read_mux = {16'h0000, output_type_reg};
			output_speed_reg_off: read_mux = output_speed_reg;
			pull_config_reg_off: read_mux = pull_config_reg;
			input_sample_reg_off: read_mux = {16'h0000, input_sample_reg};
			output_value_reg_off: read_mux = {16'h0000, output_value_reg};
			config_lock_reg_off: read_mux =
				{15'h0000, lock_key_bit, pin_lock_bit};
			alt_func_low_reg_off: read_mux = alt_func_low_reg;
			alt_func_high_reg_off: read_mux = alt_func_high_reg;
			default: read_mux = zero_word;
		endcase
	end
	always_ff @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			wb_dat_o <= zero_word;
		else if (rd)
			wb_dat_o <= read_mux;
		else
			wb_dat_o <= zero_word;
	end

	// configuration fields, byte-lane and lock gated
	always_ff @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			pin_mode_reg <= pin_mode_reset;
			output_type_reg <= 16'h0000;
			output_speed_reg <= output_speed_reset;
			pull_config_reg <= pull_config_reset;
			alt_func_low_reg <= zero_word;
			alt_func_high_reg <= zero_word;
		end
		else if (wr)
		begin
			if (wb_adr_i == pin_mode_reg_off)
				pin_mode_reg <= (pin_mode_reg & ~(sel_bits & wmask2))
					| (wb_dat_i & sel_bits & wmask2);
			if (wb_adr_i == output_type_reg_off)
				output_type_reg <= (output_type_reg
					& ~(sel_bits[15:0] & ~(pin_lock_bit & {16{lock_key_bit}})))
					| (wb_dat_i[15:0] & sel_bits[15:0]
					& ~(pin_lock_bit & {16{lock_key_bit}}));
			if (wb_adr_i == output_speed_reg_off)
				output_speed_reg <= (output_speed_reg & ~(sel_bits & wmask2))
					| (wb_dat_i & sel_bits & wmask2);
			if (wb_adr_i == pull_config_reg_off)
				pull_config_reg <= (pull_config_reg & ~(sel_bits & wmask2))
					| (wb_dat_i & sel_bits & wmask2);
			if (wb_adr_i == alt_func_low_reg_off)
				alt_func_low_reg <= (alt_func_low_reg
					& ~(sel_bits & wmask4_lo))
					| (wb_dat_i & sel_bits & wmask4_lo);
			if (wb_adr_i == alt_func_high_reg_off)
				alt_func_high_reg <= (alt_func_high_reg
					& ~(sel_bits & wmask4_hi))
					| (wb_dat_i & sel_bits & wmask4_hi);
		end
	end

	// output data: direct write, then clear, then set so set wins
	logic [15:0] next_output_value;
	always_comb
	begin
		next_output_value = output_value_reg;
		if (wr && wb_adr_i == output_value_reg_off)
			next_output_value = (output_value_reg & ~sel_bits[15:0])
				| (wb_dat_i[15:0] & sel_bits[15:0]);
		if (wr && wb_adr_i == bit_clear_only_reg_off)
			next_output_value = next_output_value
				& ~(wb_dat_i[15:0] & sel_bits[15:0]);
		if (wr && wb_adr_i == bit_set_clear_reg_off)
		begin
			next_output_value = next_output_value
				& ~(wb_dat_i[31:16] & sel_bits[31:16]);
			next_output_value = next_output_value
				| (wb_dat_i[15:0] & sel_bits[15:0]);
		end
	end
	always_ff @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			output_value_reg <= 16'h0000;
		else
			output_value_reg <= next_output_value;
	end

	// lock key sequence; mask must stay the same, whole-word writes only
	// so a write with any byte lane off sets no lock bits and drops the key sequence to idle, even one whose lanes 0-2 carry the key and the full mask
	logic key_wr;
	logic key_rd;
	logic mask_same;
	assign key_wr = wr & (wb_adr_i == config_lock_reg_off) & ~lock_key_bit;
	assign key_rd = rd & (wb_adr_i == config_lock_reg_off);
	assign mask_same = (wb_dat_i[15:0] == seq_mask);
	always_ff @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			lock_state <= key_idle;
			seq_mask <= 16'h0000;
			lock_key_bit <= 1'b0;
			pin_lock_bit <= 16'h0000;
		end
		else if (!lock_key_bit)
		begin
			if (key_wr && full_word)
				pin_lock_bit <= wb_dat_i[15:0];
			if (req && (wb_adr_i == config_lock_reg_off) && (key_wr || key_rd))
			begin
				unique case (lock_state)
					key_idle:
					begin
						if (key_wr && full_word && wb_dat_i[lock_key_pos])
						begin
							lock_state <= key_one;
							seq_mask <= wb_dat_i[15:0];
						end
					end
					key_one:
					begin
						if (key_wr && full_word && !wb_dat_i[lock_key_pos]
							&& mask_same)
							lock_state <= key_zero;
						else
							lock_state <= key_idle;
					end
					key_zero:
					begin
						if (key_wr && full_word && wb_dat_i[lock_key_pos]
							&& mask_same)
							lock_state <= key_armed;
						else
							lock_state <= key_idle;
					end
					key_armed:
					begin
						if (key_rd)
							lock_key_bit <= 1'b1;
						lock_state <= key_idle;
					end
				endcase
			end
		end
	end

	// pin sampling: three stages, change accepted when 2nd and 3rd agree
	always_ff @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			sync_a <= 16'h0000;
			sync_b <= 16'h0000;
			sync_c <= 16'h0000;
			pin_level <= 16'h0000;
		end
		else
		begin
			sync_a <= pin_in_i;
			sync_b <= sync_a;
			sync_c <= sync_b;
			pin_level <= (sync_b & sync_c) | (pin_level & (sync_b ^ sync_c));
		end
	end

	// per-pin pad control and input sampling
	logic [15:0] analog;
	logic [15:0] osc_pin;
	assign osc_pin = (fast_osc_pins & {16{fast_osc_enable_i}})
		| (slow_osc_pins & {16{slow_osc_enable_i}});
	generate
		for (g = 0; g < 16; g++)
		begin : g_pin
			logic [1:0] md;
			logic [3:0] af;
			logic drv_val;
			logic drv_en;
			assign md = pin_mode_reg[2*g +: 2];
			assign af = (g < 8) ? alt_func_low_reg[4*(g%8) +: 4]
				: alt_func_high_reg[4*(g%8) +: 4];
			assign analog[g] = (md == mode_analog);
			always_comb
			begin
				drv_val = output_value_reg[g];
				drv_en = 1'b0;
				unique case (md)
					mode_output:
					begin
						drv_val = output_value_reg[g];
						drv_en = 1'b1;
					end
					mode_alt:
					begin
						// reserved codes select nothing
						drv_val = (af <= alt_func_max) ? alt_out_i[8*g + af[2:0]]
							: 1'b0;
						drv_en = (af <= alt_func_max)
							& alt_oe_i[8*g + af[2:0]];
					end
					default:
					begin
						drv_val = 1'b0;
						drv_en = 1'b0;
					end
				endcase
			end
			// open-drain releases on one, drives low on zero
			assign pin_out_o[g] = output_type_reg[g] ? 1'b0 : drv_val;
			assign pin_oe_o[g] = ~osc_pin[g]
				& drv_en & ~(output_type_reg[g] & drv_val);
			assign pull_up_en_o[g] = ~osc_pin[g] & ~analog[g]
				& (pull_config_reg[2*g +: 2] == pull_up);
			assign pull_down_en_o[g] = ~osc_pin[g] & ~analog[g]
				& (pull_config_reg[2*g +: 2] == pull_down);
			assign schmitt_en_o[g] = ~osc_pin[g] & ~analog[g];
			assign speed_o[2*g +: 2] = output_speed_reg[2*g +: 2];
			for (genvar f = 0; f < 8; f++)
			begin : g_af
				// only the selected function sees the pin: one at a time
				assign alt_in_o[8*g + f] = (md == mode_alt)
					&& (af == 4'(f)) && pin_level[g];
			end
		end
	endgenerate
	assign osc_owned_o = osc_pin;

	// input sample register: analog pins forced to zero
	always_ff @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			input_sample_reg <= 16'h0000;
		else
			input_sample_reg <= pin_level & ~analog;
	end

	property p_set_wins;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(wr && wb_adr_i == bit_set_clear_reg_off && wb_sel_i == 4'hF)
		|=> (output_value_reg & $past(wb_dat_i[15:0]))
		== $past(wb_dat_i[15:0]);
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("set bit did not set output");
	property p_clear;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(wr && wb_adr_i == bit_set_clear_reg_off && wb_sel_i == 4'hF)
		|=> (output_value_reg & $past(wb_dat_i[31:16])
		& ~$past(wb_dat_i[15:0])) == 16'h0000;
	endproperty
	a_clear: assert property (p_clear)
		else $error("clear half did not clear output");
	property p_wo_zero;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(rd && (wb_adr_i == bit_set_clear_reg_off
		|| wb_adr_i == bit_clear_only_reg_off)) |=> wb_dat_o == zero_word;
	endproperty
	a_wo_zero: assert property (p_wo_zero)
		else $error("write-only register read nonzero");
	property p_br;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(wr && wb_adr_i == bit_clear_only_reg_off && wb_sel_i == 4'hF)
		|=> (output_value_reg & $past(wb_dat_i[15:0])) == 16'h0000;
	endproperty
	a_br: assert property (p_br)
		else $error("clear-only did not clear");
	property p_analog_zero;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(analog != 16'h0000) ##1 ($past(analog) == analog)
		|-> (input_sample_reg & analog) == 16'h0000;
	endproperty
	a_analog_zero: assert property (p_analog_zero)
		else $error("analog pin sample not zero");
	property p_key_sticky;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		lock_key_bit |=> lock_key_bit && $stable(pin_lock_bit);
	endproperty
	a_key_sticky: assert property (p_key_sticky)
		else $error("lock key or lock bits changed after locking");
	property p_lock_frozen;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(lock_key_bit && pin_lock_bit[0]) |=>
		pin_mode_reg[1:0] == $past(pin_mode_reg[1:0]);
	endproperty
	a_lock_frozen: assert property (p_lock_frozen)
		else $error("locked pin mode changed");
	property p_od;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(output_type_reg[0] && pin_mode_reg[1:0] == mode_output && !osc_pin[0])
		|-> !pin_out_o[0] && (pin_oe_o[0] == !output_value_reg[0]);
	endproperty
	a_od: assert property (p_od)
		else $error("open-drain pin driven high");
	property p_ack;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(req && mapped) |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack)
		else $error("ack not one cycle after request");
	c_lock: cover property (@(posedge core_clk_i) $rose(lock_key_bit));
	c_abort: cover property (@(posedge core_clk_i)
		lock_state == key_zero ##1 lock_state == key_idle);
	c_bsc: cover property (@(posedge core_clk_i)
		wr && wb_adr_i == bit_set_clear_reg_off);
	c_err: cover property (@(posedge core_clk_i) wb_err_o);
endmodule : gpio_port

// ==== core/gpio_port_pkg.sv ====
// package: register map, field layout and reset values of the gpio port
package gpio_port_pkg;
	localparam logic [5:0] pin_mode_reg_off = 6'h00;
	localparam logic [5:0] output_type_reg_off = 6'h04;
	localparam logic [5:0] output_speed_reg_off = 6'h08;
	localparam logic [5:0] pull_config_reg_off = 6'h0C;
	localparam logic [5:0] input_sample_reg_off = 6'h10;
	localparam logic [5:0] output_value_reg_off = 6'h14;
	localparam logic [5:0] bit_set_clear_reg_off = 6'h18;
	localparam logic [5:0] config_lock_reg_off = 6'h1C;
	localparam logic [5:0] alt_func_low_reg_off = 6'h20;
	localparam logic [5:0] alt_func_high_reg_off = 6'h24;
	localparam logic [5:0] bit_clear_only_reg_off = 6'h28;
	localparam int lock_key_pos = 16;
	localparam int clear_half_pos = 16;
	localparam logic [31:0] pin_mode_reset = 32'h0000_0000;
	localparam logic [31:0] output_speed_reset = 32'h0000_0000;
	localparam logic [31:0] pull_config_reset = 32'h0000_0000;
	localparam logic [31:0] zero_word = 32'h0000_0000;
	localparam logic [1:0] mode_input = 2'h0;
	localparam logic [1:0] mode_output = 2'h1;
	localparam logic [1:0] mode_alt = 2'h2;
	localparam logic [1:0] mode_analog = 2'h3;
	localparam logic [1:0] pull_none = 2'h0;
	localparam logic [1:0] pull_up = 2'h1;
	localparam logic [1:0] pull_down = 2'h2;
	localparam logic [3:0] alt_function_zero = 4'h0;
	localparam logic [3:0] alt_func_max = 4'h7;
	localparam int sync_stages = 3;
	typedef enum logic [3:0] {
		key_idle = 4'b0001,
		key_one = 4'b0010,
		key_zero = 4'b0100,
		key_armed = 4'b1000
	} lock_seq_e;
endpackage : gpio_port_pkg

// ==== dv/gpio_pin_model.sv ====
// pad model: resolves each pin level from port drive, outside source, pulls
module gpio_pin_model
(
	input wire logic core_clk_i,
	input wire logic [15:0] pin_out_i,
	input wire logic [15:0] pin_oe_i,
	input wire logic [15:0] pull_up_en_i,
	input wire logic [15:0] pull_down_en_i,
	input wire logic [15:0] ext_val_i,
	input wire logic [15:0] ext_en_i,
	output logic [15:0] pin_level_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] float_lvl = 16'h5A5A;

	// an undriven pad wanders every cycle, so a stale level never looks real
	always @(posedge core_clk_i)
		float_lvl <= ~float_lvl;

	// port driver wins, then the outside source, then the resistors
	always_comb
	begin
		for (int i = 0; i < 16; i++)
		begin
			if (pin_oe_i[i])
				pin_level_o[i] = pin_out_i[i];
			else if (ext_en_i[i])
				pin_level_o[i] = ext_val_i[i];
			else if (pull_up_en_i[i])
				pin_level_o[i] = 1'b1;
			else if (pull_down_en_i[i])
				pin_level_o[i] = 1'b0;
			else
				pin_level_o[i] = float_lvl[i];
		end
	end
endmodule : gpio_pin_model

// ==== dv/gpio_port_tb.sv ====
// testbench: wishbone register tests, pad behaviour and config lock
module gpio_port_tb
	import gpio_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic core_clk_i;
	logic sys_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
	logic [5:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, speed_o, r;
	logic [15:0] pin_in_i, pin_out_o, pin_oe_o, pull_up_en_o, pull_down_en_o;
	logic [15:0] schmitt_en_o, osc_owned_o, ext_val, ext_en;
	logic [127:0] alt_out_i, alt_oe_i, alt_in_o;
	logic fast_osc_enable_i, slow_osc_enable_i, e;
	int bad_count = 0;
	int checked = 0;
	localparam logic [5:0] reset_offs [10] = '{pin_mode_reg_off,
		output_type_reg_off, output_speed_reg_off, pull_config_reg_off,
		output_value_reg_off, bit_set_clear_reg_off, config_lock_reg_off,
		alt_func_low_reg_off, alt_func_high_reg_off, bit_clear_only_reg_off};

	// oscillator pins chosen so both oscillators own distinct pins
	gpio_port #(.fast_osc_pins(16'h0003), .slow_osc_pins(16'hC000)) gpio_port_i
	(
		.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
		.pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
		.pull_up_en_o(pull_up_en_o), .pull_down_en_o(pull_down_en_o),
		.schmitt_en_o(schmitt_en_o), .speed_o(speed_o),
		.alt_out_i(alt_out_i), .alt_oe_i(alt_oe_i), .alt_in_o(alt_in_o),
		.fast_osc_enable_i(fast_osc_enable_i),
		.slow_osc_enable_i(slow_osc_enable_i), .osc_owned_o(osc_owned_o)
	);

	gpio_pin_model gpio_pin_model_i
	(
		.core_clk_i(core_clk_i), .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o),
		.pull_up_en_i(pull_up_en_o), .pull_down_en_i(pull_down_en_o),
		.ext_val_i(ext_val), .ext_en_i(ext_en), .pin_level_o(pin_in_i)
	);

	// 100 MHz clock
	initial
	begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end

	task automatic conclude;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one classic cycle: hold the request until ack or err is seen high
	task automatic xfer(input logic we, input logic [5:0] adr,
		input logic [31:0] wd, output logic [31:0] rv, output logic err);
		int n;
		n = 0;
		@(posedge core_clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		// answer sampled at the rising edge, before the slave updates it
		do
		begin
			@(posedge core_clk_i);
			n++;
		end
		while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 100);
		rv = wb_dat_o;
		err = wb_err_o;
		if (n >= 100)
			chk("answer", 32'h1, 32'h0);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [5:0] adr, input logic [31:0] d);
		logic [31:0] rv;
		logic er;
		xfer(1'b1, adr, d, rv, er);
		chk("write err", 32'h0, {31'h0, er});
	endtask : wr

	task automatic rd(input logic [5:0] adr, input logic [31:0] exp);
		logic [31:0] rv;
		logic er;
		xfer(1'b0, adr, 32'h0000_0000, rv, er);
		chk($sformatf("reg %h", adr), exp, rv);
	endtask : rd

	// let the three-flop input sync and the pads settle, then look mid-cycle
	task automatic settle;
		repeat (6) @(posedge core_clk_i);
		@(negedge core_clk_i);
	endtask : settle

	// pins 0-7 use functions 0-7, pin 8 uses 7, pin 9 a reserved code
	task automatic check_alt;
		logic [15:0] eo;
		logic [127:0] ei;
		int f;
		eo = 16'h0000;
		ei = '0;
		for (int p = 0; p < 16; p++)
		begin
			f = (p < 8) ? p : (p == 8) ? 7 : (p == 9) ? 8 : 0;
			if (f < 8)
			begin
				eo[p] = alt_out_i[8 * p + f];
				ei[8 * p + f] = eo[p];
			end
		end
		chk("alt out", {16'h0, eo}, {16'h0, pin_out_o & 16'hFDFF});
		chk("alt oe", 32'h0000_FDFF, {16'h0, pin_oe_o});
		for (int k = 0; k < 4; k++)
			chk("alt in", ei[32 * k +: 32], alt_in_o[32 * k +: 32]);
	endtask : check_alt

	// watchdog: the whole run needs well under two thousand cycles
	initial
	begin
		repeat (20000) @(posedge core_clk_i);
		bad_count++;
		$display("BAD watchdog expected finish seen hang");
		conclude();
	end

	initial
	begin
		sys_rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 6'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0000_0000;
		alt_out_i = 128'hF0E1_D2C3_B4A5_9687_7869_5A4B_3C2D_1E0F;
		alt_oe_i = '1;
		fast_osc_enable_i = 1'b0;
		slow_osc_enable_i = 1'b0;
		ext_val = 16'h0000;
		ext_en = 16'h0000;
		repeat (12) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		foreach (reset_offs[i])
			rd(reset_offs[i], zero_word);
		chk("reset oe", 32'h0, {16'h0, pin_oe_o});
		xfer(1'b0, 6'h2C, zero_word, r, e);
		chk("unmapped err", 32'h1, {31'h0, e});
		wr(output_value_reg_off, 32'hFFFF_A5A5);
		rd(output_value_reg_off, 32'h0000_A5A5);
		wr(bit_set_clear_reg_off, 32'h00F0_000F);
		rd(output_value_reg_off, 32'h0000_A50F);
		wr(bit_set_clear_reg_off, 32'h0200_0200);
		rd(output_value_reg_off, 32'h0000_A70F);
		rd(bit_set_clear_reg_off, zero_word);
		wr(bit_clear_only_reg_off, 32'hFFFF_0003);
		rd(output_value_reg_off, 32'h0000_A70C);
		rd(bit_clear_only_reg_off, zero_word);
		wr(pin_mode_reg_off, 32'h5555_5555);
		settle();
		chk("pp out", 32'h0000_A70C, {16'h0, pin_out_o});
		chk("pp oe", 32'h0000_FFFF, {16'h0, pin_oe_o});
		rd(input_sample_reg_off, 32'h0000_A70C);
		wr(input_sample_reg_off, 32'h0000_FFFF);
		rd(input_sample_reg_off, 32'h0000_A70C);
		wr(output_type_reg_off, 32'hFFFF_FFFF);
		rd(output_type_reg_off, 32'h0000_FFFF);
		wr(pull_config_reg_off, 32'h5555_5555);
		@(posedge core_clk_i);
		ext_en <= 16'h8000; // outside device pulls released pin 15 low
		settle();
		chk("od oe", 32'h0000_58F3, {16'h0, pin_oe_o});
		chk("pull up", 32'h0000_FFFF, {16'h0, pull_up_en_o});
		rd(input_sample_reg_off, 32'h0000_270C);
		wr(pull_config_reg_off, 32'hAAAA_AAAA);
		settle();
		chk("pull dn", 32'h0000_FFFF, {pull_up_en_o, pull_down_en_o});
		wr(output_speed_reg_off, 32'h1234_ABCD);
		rd(output_speed_reg_off, 32'h1234_ABCD);
		chk("speed", 32'h1234_ABCD, speed_o);
		wr(pin_mode_reg_off, 32'hFFFF_FFFF);
		settle();
		chk("an oe", 32'h0, {pin_oe_o, pull_up_en_o | pull_down_en_o});
		chk("an schmitt", 32'h0, {16'h0, schmitt_en_o});
		rd(input_sample_reg_off, zero_word);
		@(posedge core_clk_i);
		ext_en <= 16'h0000;
		wr(output_type_reg_off, zero_word);
		wr(pull_config_reg_off, zero_word);
		wr(alt_func_low_reg_off, 32'h7654_3210);
		wr(alt_func_high_reg_off, 32'h0000_0087);
		wr(pin_mode_reg_off, 32'hAAAA_AAAA);
		settle();
		check_alt();
		rd(alt_func_high_reg_off, 32'h0000_0087);
		@(posedge core_clk_i);
		fast_osc_enable_i <= 1'b1;
		settle();
		chk("fast osc", 32'h0000_0003, {16'h0, osc_owned_o});
		chk("fast oe", 32'h0, {16'h0, pin_oe_o & 16'h0003});
		@(posedge core_clk_i);
		fast_osc_enable_i <= 1'b0;
		slow_osc_enable_i <= 1'b1;
		settle();
		chk("slow osc", 32'h0000_C000, {16'h0, osc_owned_o});
		@(posedge core_clk_i);
		slow_osc_enable_i <= 1'b0;
		settle();
		chk("no osc", 32'h0, {16'h0, osc_owned_o});
		wr(config_lock_reg_off, 32'h0001_00FF);
		wr(config_lock_reg_off, 32'h0000_00F0);
		wr(config_lock_reg_off, 32'h0001_00FF);
		rd(config_lock_reg_off, 32'h0000_00FF);
		rd(config_lock_reg_off, 32'h0000_00FF);
		wr(config_lock_reg_off, 32'h0001_00FF);
		wr(config_lock_reg_off, 32'h0000_00FF);
		wr(config_lock_reg_off, 32'h0001_00FF);
		rd(config_lock_reg_off, 32'h0000_00FF);
		rd(config_lock_reg_off, 32'h0001_00FF);
		wr(pin_mode_reg_off, 32'h5555_5555);
		rd(pin_mode_reg_off, 32'h5555_AAAA);
		wr(alt_func_low_reg_off, zero_word);
		rd(alt_func_low_reg_off, 32'h7654_3210);
		wr(alt_func_high_reg_off, 32'h1111_1111);
		rd(alt_func_high_reg_off, 32'h1111_1111);
		wr(config_lock_reg_off, zero_word);
		rd(config_lock_reg_off, 32'h0001_00FF);
		@(posedge core_clk_i);
		sys_rst_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		rd(config_lock_reg_off, zero_word);
		rd(pin_mode_reg_off, zero_word);
		conclude();
	end
endmodule : gpio_port_tb
